// ---- hw/e1_event_pkg.sv ----
// constants shared by the framer event-flag block
package e1_event_pkg;
    // ------------------------------------------------------------
    // register indexes; the byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_MODE = 10'h04E;
    localparam logic [9:0] IDX_STATUS = 10'h04F;
    localparam logic [9:0] IDX_EN_SYNC = 10'h050;
    localparam logic [9:0] IDX_EN_ERR = 10'h051;
    localparam logic [9:0] IDX_FLAGS_SYNC = 10'h052;
    localparam logic [9:0] IDX_FLAGS_ERR = 10'h053;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 11;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_PATTERN_SEL_BIT = 3;
    localparam int MODE_ODD_FRAME_SEL_BIT = 4;
    localparam int SYNC_W = 6;
    localparam int EXCESS_BIT = 5;
    localparam int STATE_W = 5;
    localparam int ERR_W = 8;
    localparam int SIG_MF_START_BIT = 7;
    localparam int CRC_SUBMF_START_BIT = 6;
    localparam int SIG_PATTERN_BIT = 5;
    localparam int CRC_MF_START_BIT = 4;
    localparam int CRC_PATTERN_BIT = 3;
    localparam int CRC4_ERR_BIT = 2;
    localparam int FRAME_WORD_BIT = 1;
    localparam int ALIGN_CHANGE_BIT = 0;

    // ------------------------------------------------------------
    // reset values and expected patterns
    // ------------------------------------------------------------
    localparam logic [STATE_W-1:0] STATE_RESET = 5'h0D;
    localparam logic [SYNC_W-1:0] FLAGS_SYNC_RESET = 6'h00;
    localparam logic [ERR_W-1:0] FLAGS_ERR_RESET = 8'h00;
    localparam logic [ERR_W-1:0] EN_RESET = 8'h00;
    localparam logic [3:0] SIG_MFAS_PATTERN = 4'h0;
    localparam logic [5:0] CRC_MFAS_PATTERN = 6'h0B;
    localparam logic [6:0] FAS_PATTERN = 7'h1B;
    localparam logic NFAS_BIT2_VALUE = 1'b1;
    localparam logic [3:0] CRC4_POLY_LOW = 4'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int EXCESS_WINDOW_S = 1;
    localparam int EXCESS_WINDOW_CYCLES = CLK_HZ * EXCESS_WINDOW_S;
    localparam int EXCESS_LIMIT = 915;
endpackage

// ---- hw/crc4_checker.sv ----
// serial crc-4 check of consecutive crc sub-multiframes
`timescale 1ns/1ns
module crc4_checker
    import e1_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_sync,
    input wire logic bit_en,
    input wire logic line_bit,
    input wire logic crc_slot,
    input wire logic submf_start,
    output logic crc_err
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] crc;
    logic [3:0] prev_crc;
    logic [3:0] rx_crc;
    logic [1:0] primed;
    logic data_bit;
    logic compare_now;

    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic d);
        logic fb;
        fb = c[3] ^ d;
        crc_step = {c[2:0], 1'b0} ^ (fb ? CRC4_POLY_LOW : 4'h0);
    endfunction

    // the crc bits themselves are taken as zero in the local sum
    assign data_bit = crc_slot ? 1'b0 : line_bit;
    // received bits of sub-multiframe n+1 meet the sum of n at start of n+2
    assign compare_now = bit_en & submf_start & (primed == 2'd2);

    // ------------------------------------------------------------
    // checker
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            crc <= 4'h0;
            prev_crc <= 4'h0;
            rx_crc <= 4'h0;
            primed <= 2'd0;
            crc_err <= 1'b0;
        end else if (!in_sync) begin
            primed <= 2'd0;
            crc_err <= 1'b0;
        end else begin
            crc_err <= compare_now & (rx_crc != prev_crc);
            if (bit_en) begin
                if (submf_start) begin
                    prev_crc <= crc;
                    crc <= crc_step(4'h0, data_bit);
                    if (primed != 2'd2) begin
                        primed <= primed + 2'd1;
                    end
                end else begin
                    crc <= crc_step(crc, data_bit);
                end
                if (crc_slot) begin
                    rx_crc <= {rx_crc[2:0], line_bit};
                end
            end
        end
    end
endmodule

// ---- hw/excess_crc_counter.sv ----
// crc-4 error count over a fixed window
`timescale 1ns/1ns
module excess_crc_counter
    import e1_event_pkg::*;
#(
    parameter int WINDOW_CYCLES = EXCESS_WINDOW_CYCLES,
    parameter int LIMIT = EXCESS_LIMIT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_sync,
    input wire logic err_pulse,
    output logic excess_pulse
);
    localparam int TW = $clog2(WINDOW_CYCLES + 1);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [TW-1:0] LAST_TICK = TW'(WINDOW_CYCLES - 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

    if (WINDOW_CYCLES < 2 || LIMIT < 1) begin : bad_params
        $error("excess_crc_counter: window or limit too small");
    end

    logic [TW-1:0] tick;
    logic [CW-1:0] count;
    logic window_end;
    logic reached;

    assign window_end = (tick == LAST_TICK);
    assign reached = err_pulse & (count == LIMIT_C - CW'(1));

    // ------------------------------------------------------------
    // window and count
    // ------------------------------------------------------------
    // the count saturates at the limit, so one window gives one event
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick <= '0;
            count <= '0;
            excess_pulse <= 1'b0;
        end else if (!in_sync) begin
            tick <= '0;
            count <= '0;
            excess_pulse <= 1'b0;
        end else begin
            excess_pulse <= reached;
            tick <= window_end ? '0 : tick + TW'(1);
            if (window_end) begin
                count <= '0;
            end else if (err_pulse && count != LIMIT_C) begin
                count <= count + CW'(1);
            end
        end
    end
endmodule

// ---- hw/e1_framer_event_flags.sv ----
// e1 receive framer event flags, enables and interrupt over ahb-lite
// Summary of operation
// - enable bit lets its flag assert interrupt
// - 915 crc errors in one second flags
// - excess crc count halts without crc sync
// - any status bit transition sets change flag
// - flags sticky, cleared by writing one
// - signaling multiframe start flag, only in sync
// - crc sub-multiframe start flag, only in sync
// - crc multiframe start flag, only in sync
// - signaling alignment bits not 0000 flag
// - signaling pattern check halts without sync
// - crc alignment bits not 001011 flag
// - crc pattern check halts without sync
// - crc-4 mismatch against next sub-multiframe flags
// - crc-4 check halts without crc sync
// - frame word error per selected criterion
// - frame word check halts without frame sync
// - settings pick bit, pattern or odd-frame errors; bit and pattern settings both give one event per word
// - new alignment position differing sets flag
// - first enable register gates change flags
`timescale 1ns/1ns
module e1_framer_event_flags
    import e1_event_pkg::*;
#(
    parameter int WINDOW_CYCLES = EXCESS_WINDOW_CYCLES,
    parameter int ALIGN_W = 9
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic interwork_state,
    input wire logic sig_mf_loss_state,
    input wire logic crc_mf_loss_state,
    input wire logic offline_loss_state,
    input wire logic frame_loss_state,
    input wire logic sig_mf_first_bit,
    input wire logic crc_submf_first_bit,
    input wire logic crc_mf_first_bit,
    input wire logic sig_mfas_valid,
    input wire logic [3:0] sig_mfas_bits,
    input wire logic crc_mfas_valid,
    input wire logic [5:0] crc_mfas_bits,
    input wire logic rx_bit_en,
    input wire logic rx_bit,
    input wire logic crc_slot,
    input wire logic fas_valid,
    input wire logic [6:0] fas_bits,
    input wire logic nfas_valid,
    input wire logic nfas_bit,
    input wire logic align_found,
    input wire logic [ALIGN_W-1:0] align_pos,
    output logic irq_n
);
    if (ALIGN_W < 1 || ALIGN_W > 16) begin : bad_align_w
        $error("e1_framer_event_flags: ALIGN_W out of range");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [ERR_W-1:0] mode;
    logic [ERR_W-1:0] en_sync;
    logic [ERR_W-1:0] en_err;
    logic [SYNC_W-1:0] flags_sync;
    logic [ERR_W-1:0] flags_err;
    logic [STATE_W-1:0] prev_state;
    logic [ALIGN_W-1:0] prev_align;
    logic align_known;
    logic wr_pend;
    logic [9:0] wr_idx;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire [STATE_W-1:0] state_now = {interwork_state, sig_mf_loss_state,
        crc_mf_loss_state, offline_loss_state, frame_loss_state};
    wire addr_phase = hsel & htrans[1] & hready;
    wire [9:0] rd_idx = haddr[IDX_MSB:IDX_LSB];
    wire in_map = (haddr[31:IDX_MSB+1] == '0);
    wire rd_take = addr_phase & ~hwrite;
    wire wr_data = wr_pend & hready;

    function automatic logic hit(input logic [9:0] idx, input logic [9:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    wire wr_mode = wr_data & hit(wr_idx, IDX_MODE);
    wire wr_en_sync = wr_data & hit(wr_idx, IDX_EN_SYNC);
    wire wr_en_err = wr_data & hit(wr_idx, IDX_EN_ERR);
    wire wr_flags_sync = wr_data & hit(wr_idx, IDX_FLAGS_SYNC);
    wire wr_flags_err = wr_data & hit(wr_idx, IDX_FLAGS_ERR);

    // unmapped or reserved locations read as zero
    wire [ERR_W-1:0] rd_mux =
        !in_map ? 8'h00 :
        hit(rd_idx, IDX_MODE) ? mode :
        hit(rd_idx, IDX_STATUS) ? {3'h0, state_now} :
        hit(rd_idx, IDX_EN_SYNC) ? en_sync :
        hit(rd_idx, IDX_EN_ERR) ? en_err :
        hit(rd_idx, IDX_FLAGS_SYNC) ? {2'h0, flags_sync} :
        hit(rd_idx, IDX_FLAGS_ERR) ? flags_err : 8'h00;

    // ------------------------------------------------------------
    // event detectors
    // ------------------------------------------------------------
    wire crc_sync = ~crc_mf_loss_state;
    wire sig_sync = ~sig_mf_loss_state;
    wire frame_sync = ~frame_loss_state;
    wire pattern_count_sel = mode[MODE_PATTERN_SEL_BIT];
    wire odd_frame_count_sel = mode[MODE_ODD_FRAME_SEL_BIT];
    wire [6:0] fas_diff = fas_bits ^ FAS_PATTERN;
    // bit and pattern criteria agree on whether a word produced any event;
    // and each gives one event per word however many bits differ
    wire fas_bit_err = fas_valid & (pattern_count_sel ? (fas_diff != 7'h00)
        : (|fas_diff));
    wire nfas_err = nfas_valid & odd_frame_count_sel & (nfas_bit != NFAS_BIT2_VALUE);
    wire word_event = frame_sync & (fas_bit_err | nfas_err);
    wire sig_pat_event = sig_sync & sig_mfas_valid
        & (sig_mfas_bits != SIG_MFAS_PATTERN);
    wire crc_pat_event = crc_sync & crc_mfas_valid
        & (crc_mfas_bits != CRC_MFAS_PATTERN);
    wire sig_start_event = sig_sync & sig_mf_first_bit;
    wire submf_start_event = crc_sync & crc_submf_first_bit;
    wire mf_start_event = crc_sync & crc_mf_first_bit;
    wire align_event = align_found & align_known & (align_pos != prev_align);
    wire [STATE_W-1:0] change_event = state_now ^ prev_state;
    wire crc4_event;
    wire excess_event;

    crc4_checker crc_check (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_sync(crc_sync),
        .bit_en(rx_bit_en),
        .line_bit(rx_bit),
        .crc_slot(crc_slot),
        .submf_start(crc_submf_first_bit),
        .crc_err(crc4_event)
    );

    excess_crc_counter #(
        .WINDOW_CYCLES(WINDOW_CYCLES),
        .LIMIT(EXCESS_LIMIT)
    ) excess_count (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_sync(crc_sync),
        .err_pulse(crc4_event),
        .excess_pulse(excess_event)
    );

    wire [ERR_W-1:0] err_set = {sig_start_event, submf_start_event, sig_pat_event,
        mf_start_event, crc_pat_event, crc4_event, word_event, align_event};
    wire [SYNC_W-1:0] sync_set = {excess_event, change_event};
    wire [SYNC_W-1:0] sync_clr = wr_flags_sync ? hwdata[SYNC_W-1:0] : '0;
    wire [ERR_W-1:0] err_clr = wr_flags_err ? hwdata[ERR_W-1:0] : '0;
    // an event in the clearing cycle survives the clear
    wire [SYNC_W-1:0] next_flags_sync = (flags_sync & ~sync_clr) | sync_set;
    wire [ERR_W-1:0] next_flags_err = (flags_err & ~err_clr) | err_set;
    wire any_pending = |(next_flags_sync & en_sync[SYNC_W-1:0])
        | |(next_flags_err & en_err);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // zero wait states; a read right after a write sees the old value
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_pend <= 1'b0;
            wr_idx <= 10'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (hready) begin
                wr_pend <= addr_phase & hwrite & in_map;
                wr_idx <= rd_idx;
            end
            if (rd_take) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode <= EN_RESET;
            en_sync <= EN_RESET;
            en_err <= EN_RESET;
        end else begin
            if (wr_mode) begin
                mode <= hwdata[ERR_W-1:0]
                    & ((8'h01 << MODE_PATTERN_SEL_BIT) | (8'h01 << MODE_ODD_FRAME_SEL_BIT));
            end
            if (wr_en_sync) begin
                en_sync <= {2'h0, hwdata[SYNC_W-1:0]};
            end
            if (wr_en_err) begin
                en_err <= hwdata[ERR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // flags, history and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flags_sync <= FLAGS_SYNC_RESET;
            flags_err <= FLAGS_ERR_RESET;
            prev_state <= STATE_RESET;
            prev_align <= '0;
            align_known <= 1'b0;
            irq_n <= 1'b1;
        end else begin
            flags_sync <= next_flags_sync;
            flags_err <= next_flags_err;
            prev_state <= state_now;
            if (align_found) begin
                prev_align <= align_pos;
                align_known <= 1'b1;
            end
            irq_n <= ~any_pending;
        end
    end
endmodule

// ---- verification/e1_line_model.sv ----
// line-side model: sync levels, one-cycle framer events and line bits
`timescale 1ns/1ns
module e1_line_model (
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic [3:0] kind,
    input wire logic [8:0] val,
    input wire logic [4:0] states,
    input wire logic line_on,
    input wire logic line_bit,
    output logic [4:0] state_out = 5'h0D,
    output logic [7:0] pulse = 8'h00,
    output logic [8:0] data = 9'h000,
    output logic rx_bit_en = 1'b0,
    output logic rx_bit = 1'b0,
    output logic crc_slot = 1'b0
);
    always @(posedge sys_clk) begin
        state_out <= states;
        pulse <= fire ? 8'h01 << kind : 8'h00;
        // idle data lines flip so the block cannot lean on a stale value
        data <= fire ? val : ~data;
        // while line_on is high every cycle is a line bit, so a sub-multiframe start meets one
        rx_bit_en <= line_on;
        rx_bit <= line_bit;
        crc_slot <= line_bit ^ rx_bit;
    end
endmodule

// ---- verification/e1_framer_event_flags_checker.sv ----
// bus answer and interrupt output checks of the event-flag block
`timescale 1ns/1ns
module e1_framer_event_flags_checker
    import e1_event_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic interwork_state,
    input wire logic sig_mf_loss_state,
    input wire logic crc_mf_loss_state,
    input wire logic offline_loss_state,
    input wire logic frame_loss_state,
    input wire logic sig_mf_first_bit,
    input wire logic crc_submf_first_bit,
    input wire logic crc_mf_first_bit,
    input wire logic sig_mfas_valid,
    input wire logic crc_mfas_valid,
    input wire logic rx_bit_en,
    input wire logic fas_valid,
    input wire logic nfas_valid,
    input wire logic align_found,
    input wire logic irq_n
);
    // ----
    // helper logic
    // ----
    logic taken;
    logic wr_dph;
    logic en_dph;
    logic [7:0] en_shadow;
    logic [4:0] st;
    logic [4:0] st_q;
    logic rx_q1;
    logic rx_q2;
    logic cause_q;
    assign taken = hsel & htrans[1] & hready;
    assign st = {interwork_state, sig_mf_loss_state, crc_mf_loss_state,
        offline_loss_state, frame_loss_state};
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_dph <= 1'b0;
            en_dph <= 1'b0;
            en_shadow <= EN_RESET;
            st_q <= STATE_RESET;
            rx_q1 <= 1'b0;
            rx_q2 <= 1'b0;
            cause_q <= 1'b0;
        end else begin
            st_q <= st;
            rx_q1 <= rx_bit_en;
            rx_q2 <= rx_q1;
            // inputs of one edge become the flag and interrupt at the next
            cause_q <= sig_mf_first_bit || crc_submf_first_bit || crc_mf_first_bit
                || sig_mfas_valid || crc_mfas_valid || fas_valid || nfas_valid
                || align_found || st != st_q || rx_bit_en || rx_q1 || rx_q2;
            wr_dph <= taken & hwrite;
            en_dph <= taken & hwrite & (haddr == {20'h0, IDX_EN_ERR, 2'b00});
            if (en_dph) begin
                en_shadow <= hwdata[7:0];
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ----
    // properties
    // ----
    // crc-4 and excess flags trail their line bit by up to two cycles
    // an enable write shows on the interrupt two edges after its data phase
    sequence cause;
        cause_q || $past(wr_dph, 2);
    endsequence
    sequence rd_taken(logic [9:0] idx);
        taken && !hwrite && haddr == {20'h0, idx, 2'b00};
    endsequence
    property en_back;
        logic [7:0] v;
        (rd_taken(IDX_EN_ERR), v = en_shadow) |=> hrdata == {24'h0, v};
    endproperty
    ready_a: assert property (hreadyout) else $error("wait state inserted");
    okay_a: assert property (!hresp) else $error("error response given");
    irq_fall_a: assert property ($fell(irq_n) |-> cause)
        else $error("interrupt asserted without cause");
    irq_hold_a: assert property (!irq_n && !wr_dph && !$past(wr_dph) |=> !irq_n)
        else $error("interrupt released without a write");
    en_read_a: assert property (en_back) else $error("enable readback wrong");
    unmapped_a: assert property (taken && !hwrite && haddr[31:12] != 20'h0 |=> hrdata == 0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (taken && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    release_a: assert property ($fell(reset) |-> irq_n)
        else $error("interrupt low at reset release");
endmodule

bind e1_framer_event_flags e1_framer_event_flags_checker e1_framer_event_flags_checker_inst (
    .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .interwork_state, .sig_mf_loss_state, .crc_mf_loss_state,
    .offline_loss_state, .frame_loss_state, .sig_mf_first_bit, .crc_submf_first_bit,
    .crc_mf_first_bit, .sig_mfas_valid, .crc_mfas_valid, .rx_bit_en, .fas_valid,
    .nfas_valid, .align_found, .irq_n);

// ---- verification/tb_e1_framer_event_flags.sv ----
// self-checking bench of the framer event-flag block
`timescale 1ns/1ns
module tb_e1_framer_event_flags;
    import e1_event_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq_n;
    logic fire = 1'b0;
    logic line_on = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [8:0] val = 9'h000;
    logic [4:0] states = STATE_RESET;
    logic [31:0] seed = 32'h8A6E7097;
    logic [4:0] st;
    logic [7:0] pulse;
    logic [8:0] data;
    logic rx_bit_en;
    logic rx_bit;
    logic crc_slot;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic have_pos = 1'b0;
    logic [8:0] last_pos = 9'h000;
    logic [9:0] reg_idx [4] = '{IDX_FLAGS_SYNC, IDX_FLAGS_ERR, IDX_EN_ERR, 10'h3FF};
    logic [7:0] reg_rst [4] = '{{2'h0, FLAGS_SYNC_RESET}, FLAGS_ERR_RESET, EN_RESET, 8'h00};

    always #50 sys_clk = ~sys_clk;

    e1_line_model e1_line_model_inst (.sys_clk, .fire, .kind, .val, .states, .line_on,
        .line_bit(seed[0]), .state_out(st), .pulse, .data, .rx_bit_en, .rx_bit, .crc_slot);
    // short excess window keeps a window reachable in simulation
    e1_framer_event_flags #(.WINDOW_CYCLES(2000)) e1_framer_event_flags_inst (
        .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp(), .interwork_state(st[4]),
        .sig_mf_loss_state(st[3]), .crc_mf_loss_state(st[2]), .offline_loss_state(st[1]),
        .frame_loss_state(st[0]), .sig_mf_first_bit(pulse[0]), .crc_submf_first_bit(pulse[1]),
        .crc_mf_first_bit(pulse[2]), .sig_mfas_valid(pulse[3]), .sig_mfas_bits(data[3:0]),
        .crc_mfas_valid(pulse[4]), .crc_mfas_bits(data[5:0]), .rx_bit_en, .rx_bit, .crc_slot,
        .fas_valid(pulse[5]), .fas_bits(data[6:0]), .nfas_valid(pulse[6]), .nfas_bit(data[0]),
        .align_found(pulse[7]), .align_pos(data), .irq_n);

    // ----
    // tasks and expectations
    // ----
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_err(input logic [3:0] k, input logic [8:0] v,
        input logic [4:0] s, input logic [7:0] m);
        logic [7:0] f;
        f = 8'h00;
        case (k)
            0: f[SIG_MF_START_BIT] = !s[3];
            1: f[CRC_SUBMF_START_BIT] = !s[2];
            2: f[CRC_MF_START_BIT] = !s[2];
            3: f[SIG_PATTERN_BIT] = !s[3] && v[3:0] != SIG_MFAS_PATTERN;
            4: f[CRC_PATTERN_BIT] = !s[2] && v[5:0] != CRC_MFAS_PATTERN;
            5: f[FRAME_WORD_BIT] = !s[0] && v[6:0] != FAS_PATTERN;
            6: f[FRAME_WORD_BIT] = !s[0] && m[MODE_ODD_FRAME_SEL_BIT] && v[0] != NFAS_BIT2_VALUE;
            default: f[ALIGN_CHANGE_BIT] = have_pos && v != last_pos;
        endcase
        return f;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, idx, 2'b00};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // model needs one edge, the block a second, the third lets outputs settle
    task automatic send(input logic [3:0] k, input logic [8:0] v);
        kind <= k;
        val <= v;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    // ----
    // main sequence
    // ----
    initial begin
        logic [3:0] k;
        logic [4:0] s;
        logic [7:0] m;
        logic [7:0] msk;
        logic [8:0] v;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b1, 10'h3FF, 8'hFF);
        foreach (reg_idx[j]) begin
            bus(1'b0, reg_idx[j], 8'h00);
            check(rd, {24'h0, reg_rst[j]});
        end
        $display("reset values done");
        for (int j = 0; j < STATE_W; j++) begin
            states[j] <= ~states[j];
            repeat (3) @(posedge sys_clk);
            bus(1'b1, IDX_FLAGS_SYNC, 8'h00);
            bus(1'b0, IDX_FLAGS_SYNC, 8'h00);
            check(rd, 32'h1 << j);
            bus(1'b1, IDX_FLAGS_SYNC, 8'h01 << j);
            bus(1'b0, IDX_FLAGS_SYNC, 8'h00);
            check(rd, 32'h0);
        end
        $display("status changes done");
        bus(1'b1, IDX_FLAGS_ERR, 8'hFF);
        bus(1'b1, IDX_EN_ERR, 8'h01 << SIG_MF_START_BIT);
        send(4'h2, 9'h000);
        check({31'h0, irq_n}, 32'h1);
        send(4'h0, 9'h000);
        check({31'h0, irq_n}, 32'h0);
        bus(1'b1, IDX_FLAGS_ERR, 8'h01 << SIG_MF_START_BIT);
        @(posedge sys_clk);
        check({31'h0, irq_n}, 32'h1);
        bus(1'b1, IDX_EN_SYNC, 8'h01);
        states[0] <= ~states[0];
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq_n}, 32'h0);
        bus(1'b1, IDX_FLAGS_SYNC, 8'h01);
        @(posedge sys_clk);
        check({31'h0, irq_n}, 32'h1);
        bus(1'b0, IDX_EN_ERR, 8'h00);
        check(rd, 32'h80);
        $display("interrupt gating done");
        line_on <= 1'b1;
        for (int i = 0; i < 48; i++) begin
            seed = xs(seed);
            k = 4'(i % 8);
            s = (seed[9:5] & 5'h0D) | 5'h12;
            m = {3'h0, seed[11:10], 3'h0};
            v = seed[4] ? seed[20:12] : (k == 3) ? 9'h000 : (k == 4) ? {3'h0, CRC_MFAS_PATTERN}
                : (k == 5) ? {2'h0, FAS_PATTERN} : (k == 7) ? last_pos : 9'h001;
            // live crc-4 checking on random line bits hides that bit while in sync
            msk = s[2] ? 8'hFF : ~(8'h01 << CRC4_ERR_BIT);
            states <= s;
            bus(1'b1, IDX_MODE, m);
            bus(1'b1, IDX_FLAGS_ERR, 8'hFF);
            send(k, v);
            bus(1'b0, IDX_FLAGS_ERR, 8'h00);
            check(rd & msk, exp_err(k, v, s, m) & msk);
            if (k == 7) begin
                have_pos = 1'b1;
                last_pos = v;
            end
        end
        line_on <= 1'b0;
        $display("random events done");
        close_out();
    end
endmodule
